/* sfpw_pkg.sv */
package sfpw_pkg;
    // opcodes
    localparam logic [7:0] OP_WRAP_SET = 8'h77;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_READ_STATUS1 = 8'h05;
    localparam logic [7:0] OP_READ_STATUS2 = 8'h35;
    // status bit positions
    localparam int BUSY_BIT_POS = 0;
    localparam int WEL_BIT_POS = 1;
    localparam int QE_BIT_POS = 1;
    // wrap configuration byte fields
    localparam int WRAP_DIS_POS = 4;
    localparam int WRAP_LEN_LO = 5;
    localparam logic [7:0] WRAP_USED_MASK = 8'h70;
    localparam logic [7:0] WRAP_DEFAULT = 8'h10;
    // frame sizes
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // spi clock divider: serial clock toggles every DIV_HALF core cycles
    localparam logic [3:0] DIV_HALF = 4'h2;

    typedef enum logic [2:0] {
        CMD_WRAP = 3'h0,
        CMD_PROG = 3'h1,
        CMD_QPROG = 3'h2,
        CMD_ERASE_4K = 3'h3,
        CMD_ERASE_32K = 3'h4,
        CMD_ERASE_64K = 3'h5
    } sfpw_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_POLL = 4'h1,
        ST_WREN = 4'h2,
        ST_CHKWEL = 4'h3,
        ST_CHKQE = 4'h4,
        ST_OPCODE = 4'h5,
        ST_ADDR = 4'h6,
        ST_DATA = 4'h7,
        ST_WAIT = 4'h8,
        ST_GAP = 4'h9,
        ST_DONE = 4'ha
    } sfpw_state_t;
endpackage

/* sfpw_shifter.sv */
`timescale 1ns/10ps
// one spi frame segment: shifts out for nbits clocks (1 or 4 lines each), captures io1 before each fall
module sfpw_shifter
    import sfpw_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic quad_in,
    input wire logic [5:0] nbits_in,
    input wire logic [31:0] tx_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic [3:0] io_out,
    output logic [7:0] rx_out,
    output logic done_out
);
    typedef struct packed {
        logic busy;
        logic sclk;
        logic [3:0] div;
        logic [5:0] left;
        logic [31:0] sh;
        logic [7:0] rx;
        logic done;
    } sfpw_sh_t;

    sfpw_sh_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (!s_r.busy) begin
            if (start_in) begin
                s_nxt.busy = 1'b1;
                s_nxt.sh = tx_in;
                s_nxt.left = nbits_in;
                s_nxt.div = 4'h0;
            end
        end else if (s_r.div == DIV_HALF - 4'h1) begin
            s_nxt.div = 4'h0;
            if (!s_r.sclk) begin
                s_nxt.sclk = 1'b1;
            end else begin
                // sample late: pin register plus synchroniser exceed half a clock
                s_nxt.sclk = 1'b0;
                s_nxt.rx = {s_r.rx[6:0], miso_in};
                s_nxt.sh = quad_in ? {s_r.sh[27:0], 4'h0} : {s_r.sh[30:0], 1'b0};
                if (s_r.left == 6'h1) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                end
                s_nxt.left = s_r.left - 6'h1;
            end
        end else begin
            s_nxt.div = s_r.div + 4'h1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sclk_out = s_r.sclk;
    assign io_out = quad_in ? s_r.sh[31:28] : {3'h0, s_r.sh[31]};
    assign rx_out = s_r.rx;
    assign done_out = s_r.done;
endmodule

/* sfpw_host.sv */
`timescale 1ns/10ps
module sfpw_host
    import sfpw_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire sfpw_cmd_t cmd_in,
    input wire logic [23:0] cmd_addr_in,
    input wire logic [7:0] cmd_wrap_in,
    input wire logic [8:0] cmd_len_in,
    input wire logic wdata_valid_in,
    input wire logic [7:0] wdata_in,
    input wire logic flash_io1_in,
    output logic cmd_ready_out,
    output logic wdata_ready_out,
    output logic done_out,
    output logic error_out,
    output logic flash_cs_n_out,
    output logic flash_sclk_out,
    output logic [3:0] flash_io_out,
    output logic [3:0] flash_io_oe_out
);
    typedef struct packed {
        sfpw_state_t st;
        sfpw_cmd_t cmd;
        logic [23:0] addr;
        logic [7:0] wrap;
        logic [8:0] left;
        logic [7:0] data;
        logic cs_n;
        logic quad_phase;
        logic start;
        logic [5:0] nbits;
        logic [31:0] tx;
        logic [1:0] sub;
        logic done;
        logic err;
        logic wready;
        logic sclk;
        logic [3:0] io;
        logic [3:0] oe;
        logic rdy;
    } sfpw_host_t;

    sfpw_host_t r_r, r_nxt;
    logic miso_meta_r, miso_sync_r;
    logic sh_sclk, sh_done;
    logic [3:0] sh_io;
    logic [7:0] sh_rx;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            miso_meta_r <= 1'b0;
            miso_sync_r <= 1'b0;
        end else begin
            miso_meta_r <= flash_io1_in;
            miso_sync_r <= miso_meta_r;
        end
    end

    sfpw_shifter u_shift (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(r_r.start),
        .quad_in(r_r.quad_phase),
        .nbits_in(r_r.nbits),
        .tx_in(r_r.tx),
        .miso_in(miso_sync_r),
        .sclk_out(sh_sclk),
        .io_out(sh_io),
        .rx_out(sh_rx),
        .done_out(sh_done)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] region_base(input sfpw_cmd_t c, input logic [23:0] a);
        case (c)
            CMD_ERASE_4K: region_base = {a[23:12], 12'h000};
            CMD_ERASE_32K: region_base = {a[23:15], 15'h0000};
            CMD_ERASE_64K: region_base = {a[23:16], 16'h0000};
            default: region_base = a;
        endcase
    endfunction

    always_comb begin
        r_nxt = r_r;
        r_nxt.start = 1'b0;
        r_nxt.done = 1'b0;
        r_nxt.wready = 1'b0;
        // sub: 0 = issue segment, 1 = await segment end
        case (r_r.st)
            ST_IDLE: begin
                r_nxt.cs_n = 1'b1;
                if (cmd_valid_in) begin
                    r_nxt.cmd = cmd_in;
                    r_nxt.addr = region_base(cmd_in, cmd_addr_in);
                    r_nxt.wrap = cmd_wrap_in & WRAP_USED_MASK;
                    // clamp to remaining page so a partial page stays untouched
                    if (cmd_len_in == 9'h0) begin
                        r_nxt.left = 9'h1;
                    end else if (cmd_len_in > PAGE_BYTES - {1'b0, cmd_addr_in[7:0]}) begin
                        r_nxt.left = PAGE_BYTES - {1'b0, cmd_addr_in[7:0]};
                    end else begin
                        r_nxt.left = cmd_len_in;
                    end
                    r_nxt.err = 1'b0;
                    r_nxt.sub = 2'h0;
                    r_nxt.st = ST_POLL;
                end
            end
            // read status: ST_POLL repeats until not busy (a busy device would drop the frame); ST_CHKWEL and ST_CHKQE read once
            ST_POLL, ST_CHKWEL, ST_CHKQE: begin
                if (r_r.sub == 2'h0) begin
                    r_nxt.cs_n = 1'b0;
                    r_nxt.quad_phase = 1'b0;
                    r_nxt.nbits = 6'h10;
                    r_nxt.tx = {(r_r.st == ST_CHKQE) ? OP_READ_STATUS2 : OP_READ_STATUS1,
                                24'h0};
                    r_nxt.start = 1'b1;
                    r_nxt.sub = 2'h1;
                end else if (sh_done) begin
                    r_nxt.cs_n = 1'b1;
                    r_nxt.sub = 2'h0;
                    if (r_r.st == ST_POLL) begin
                        if (!sh_rx[BUSY_BIT_POS]) begin
                            r_nxt.st = (r_r.cmd == CMD_WRAP) ? ST_OPCODE : ST_WREN;
                        end else begin
                            r_nxt.st = ST_GAP;
                        end
                    end else if (r_r.st == ST_CHKWEL) begin
                        if (!sh_rx[WEL_BIT_POS]) begin
                            r_nxt.err = 1'b1;
                            r_nxt.st = ST_DONE;
                        end else begin
                            r_nxt.st = (r_r.cmd == CMD_QPROG) ? ST_CHKQE : ST_OPCODE;
                        end
                    end else if (!sh_rx[QE_BIT_POS]) begin
                        r_nxt.err = 1'b1;
                        r_nxt.st = ST_DONE;
                    end else begin
                        r_nxt.st = ST_OPCODE;
                    end
                end
            end
            ST_GAP: begin
                r_nxt.st = ST_POLL;
            end
            ST_WREN: begin
                if (r_r.sub == 2'h0) begin
                    r_nxt.cs_n = 1'b0;
                    r_nxt.quad_phase = 1'b0;
                    r_nxt.nbits = {2'h0, BYTE_BITS};
                    r_nxt.tx = {OP_WRITE_EN, 24'h0};
                    r_nxt.start = 1'b1;
                    r_nxt.sub = 2'h1;
                end else if (sh_done) begin
                    r_nxt.cs_n = 1'b1;
                    r_nxt.sub = 2'h0;
                    r_nxt.st = ST_CHKWEL;
                end
            end
            ST_OPCODE: begin
                if (r_r.sub == 2'h0) begin
                    r_nxt.cs_n = 1'b0;
                    r_nxt.quad_phase = 1'b0;
                    r_nxt.nbits = {2'h0, BYTE_BITS};
                    case (r_r.cmd)
                        CMD_WRAP: r_nxt.tx = {OP_WRAP_SET, 24'h0};
                        CMD_PROG: r_nxt.tx = {OP_PAGE_PROG, 24'h0};
                        CMD_QPROG: r_nxt.tx = {OP_QUAD_PROG, 24'h0};
                        CMD_ERASE_4K: r_nxt.tx = {OP_ERASE_4K, 24'h0};
                        CMD_ERASE_32K: r_nxt.tx = {OP_ERASE_32K, 24'h0};
                        default: r_nxt.tx = {OP_ERASE_64K, 24'h0};
                    endcase
                    r_nxt.start = 1'b1;
                    r_nxt.sub = 2'h1;
                end else if (sh_done) begin
                    r_nxt.sub = 2'h0;
                    r_nxt.st = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (r_r.sub == 2'h0) begin
                    r_nxt.quad_phase = (r_r.cmd == CMD_QPROG);
                    r_nxt.nbits = (r_r.cmd == CMD_QPROG) ? 6'h06 : ADDR_BITS;
                    // wrap setup sends 24 dummy zeros in the address slot
                    r_nxt.tx = (r_r.cmd == CMD_WRAP) ? 32'h0 : {r_r.addr, 8'h0};
                    r_nxt.start = 1'b1;
                    r_nxt.sub = 2'h1;
                end else if (sh_done) begin
                    r_nxt.sub = 2'h0;
                    r_nxt.st = (r_r.cmd == CMD_WRAP || r_r.cmd == CMD_PROG ||
                                r_r.cmd == CMD_QPROG) ? ST_DATA : ST_WAIT;
                end
            end
            ST_DATA: begin
                if (r_r.sub == 2'h0) begin
                    if (r_r.cmd == CMD_WRAP) begin
                        // sent once: the device keeps it for every later quad read
                        r_nxt.tx = {r_r.wrap, 24'h0};
                        r_nxt.nbits = {2'h0, BYTE_BITS};
                        r_nxt.start = 1'b1;
                        r_nxt.sub = 2'h1;
                    end else if (wdata_valid_in) begin
                        // cs stays low while waiting for data: stalls just stretch sclk
                        r_nxt.wready = 1'b1;
                        r_nxt.tx = {wdata_in, 24'h0};
                        r_nxt.nbits = (r_r.cmd == CMD_QPROG) ? 6'h02 : {2'h0, BYTE_BITS};
                        r_nxt.start = 1'b1;
                        r_nxt.sub = 2'h1;
                    end
                end else if (sh_done) begin
                    r_nxt.sub = 2'h0;
                    if (r_r.cmd == CMD_WRAP || r_r.left == 9'h1) begin
                        r_nxt.st = ST_WAIT;
                    end
                    r_nxt.left = r_r.left - 9'h1;
                end
            end
            ST_WAIT: begin
                // raise cs right after the last bit of the final byte
                r_nxt.cs_n = 1'b1;
                r_nxt.sub = 2'h0;
                r_nxt.st = (r_r.cmd == CMD_WRAP) ? ST_DONE : ST_POLL;
                r_nxt.cmd = (r_r.cmd == CMD_WRAP) ? r_r.cmd : CMD_WRAP;
                // mark post-cycle polls so they finish instead of writing again
                r_nxt.wrap[0] = (r_r.cmd != CMD_WRAP);
            end
            ST_DONE: begin
                r_nxt.done = 1'b1;
                r_nxt.st = ST_IDLE;
            end
            default: begin
                r_nxt.st = ST_IDLE;
            end
        endcase
        // final poll after the cycle ends: cmd was retagged as wrap to skip wren
        // a protected target never goes busy, so this poll still ends the job
        if (r_r.st == ST_POLL && r_r.sub == 2'h1 && sh_done && !sh_rx[BUSY_BIT_POS]
            && r_r.cmd == CMD_WRAP && r_r.wrap[0]) begin
            r_nxt.st = ST_DONE;
        end
        r_nxt.sclk = sh_sclk;
        r_nxt.io = sh_io;
        r_nxt.oe = (r_nxt.cs_n) ? 4'h0 : (r_nxt.quad_phase ? 4'hf : 4'h1);
        r_nxt.rdy = (r_nxt.st == ST_IDLE);
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            // no wrap copy kept here: the device restores its own default
            r_r <= '0;
            r_r.st <= ST_IDLE;
            r_r.cs_n <= 1'b1;
            r_r.rdy <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign cmd_ready_out = r_r.rdy;
    assign wdata_ready_out = r_r.wready;
    assign done_out = r_r.done;
    assign error_out = r_r.err;
    assign flash_cs_n_out = r_r.cs_n;
    assign flash_sclk_out = r_r.sclk;
    assign flash_io_out = r_r.io;
    assign flash_io_oe_out = r_r.oe;
endmodule

/* sfpw_sva.sv */
`timescale 1ns/10ps
module sfpw_sva
    import sfpw_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_ready_out,
    input wire logic done_out,
    input wire logic error_out,
    input wire logic flash_cs_n_out,
    input wire logic flash_sclk_out,
    input wire logic [3:0] flash_io_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // bits seen in the current frame; quad clocks carry four
    logic [15:0] bits_r;
    logic sclk_q_r;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bits_r <= 16'h0;
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= flash_sclk_out;
            if (flash_cs_n_out) begin
                bits_r <= 16'h0;
            end else if (flash_sclk_out && !sclk_q_r) begin
                bits_r <= bits_r + ((flash_io_oe_out == 4'hf) ? 16'h4 : 16'h1);
            end
        end
    end
    chk_byte_frame: assert property ($rose(flash_cs_n_out) |-> bits_r[2:0] == 3'h0)
        else $error("chip select rose inside a byte");
    chk_sclk_in_frame: assert property (flash_sclk_out |-> !flash_cs_n_out)
        else $error("serial clock toggles outside a frame");
    chk_idle_cs_high: assert property (cmd_ready_out |-> flash_cs_n_out)
        else $error("chip select low while idle");
    chk_sclk_high_half: assert property ($rose(flash_sclk_out) |=> flash_sclk_out ##1 !flash_sclk_out)
        else $error("serial clock high phase wrong");
    chk_sclk_low_half: assert property ($fell(flash_sclk_out) |=> !flash_sclk_out)
        else $error("serial clock low phase too short");
    chk_done_pulse: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    chk_error_done: assert property ($rose(error_out) |=> done_out)
        else $error("error raised without done");
    chk_error_clear: assert property (cmd_valid_in && cmd_ready_out |=> !error_out && !cmd_ready_out)
        else $error("error not cleared or ready held on new command");
    chk_done_cs: assert property (done_out |-> flash_cs_n_out)
        else $error("done while chip select low");
    cover property (done_out && error_out);
    cover property (done_out && !error_out);
    cover property (flash_io_oe_out == 4'hf);
endmodule

bind sfpw_host sfpw_sva u_sva (.core_clk_in, .rst_in, .cmd_valid_in, .cmd_ready_out, .done_out,
    .error_out, .flash_cs_n_out, .flash_sclk_out, .flash_io_oe_out);

/* sfpw_flash_model.sv */
`timescale 1ns/10ps
module sfpw_flash_model
    import sfpw_pkg::*;
(
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic [3:0] io_in,
    output logic io1_out
);
    logic [7:0] mem [int];
    logic [7:0] pend [int];
    logic [7:0] op, sh, obuf;
    logic [7:0] wrap_r = WRAP_DEFAULT;
    logic [23:0] addr;
    logic write_enable_latch = 1'b0, busy = 1'b0, qe = 1'b1, wel_block = 1'b0;
    int nb, k, sz, busy_ns = 2000;
    initial io1_out = 1'b0;
    task automatic start_cycle();
        busy = 1'b1;
        busy <= #(busy_ns) 1'b0;
        write_enable_latch <= #(busy_ns) 1'b0;
    endtask
    always @(negedge cs_n_in) begin
        nb = 0;
        pend.delete();
    end
    always @(posedge sclk_in) if (!cs_n_in) begin
        if (nb >= 8 && op == OP_QUAD_PROG && qe) begin
            sh = {sh[3:0], io_in};
            nb += 4;
        end else begin
            sh = {sh[6:0], io_in[0]};
            nb += 1;
        end
        if (nb % 8 == 0) begin
            k = nb / 8;
            if (k == 1) op = sh;
            else if (k <= 4) addr = {addr[15:0], sh};
            else pend[{addr[23:8], 8'(addr[7:0] + k - 5)}] = sh;
            // status refreshed every byte so polls see busy fall
            obuf = (op == OP_READ_STATUS2) ? {6'h0, qe, 1'b0} : {6'h0, write_enable_latch, busy};
        end
    end
    always @(negedge sclk_in) if (!cs_n_in && nb >= 8) begin
        io1_out <= obuf[7];
        obuf = obuf << 1;
    end
    always @(posedge cs_n_in) begin
        io1_out <= ~io1_out;
        if (nb % 8 == 0 && !busy) begin
            if (op == OP_WRITE_EN && nb == 8) write_enable_latch = !wel_block;
            else if (op == OP_WRAP_SET && nb == 40) wrap_r = sh & WRAP_USED_MASK;
            else if (write_enable_latch && nb >= 40 && (op == OP_PAGE_PROG || op == OP_QUAD_PROG)) begin
                foreach (pend[a]) mem[a] = pend[a] & (mem.exists(a) ? mem[a] : 8'hff);
                start_cycle();
            end else if (write_enable_latch && nb == 32 && (op == OP_ERASE_4K || op == OP_ERASE_32K
                    || op == OP_ERASE_64K)) begin
                sz = (op == OP_ERASE_4K) ? 4096 : (op == OP_ERASE_32K) ? 32768 : 65536;
                for (k = 0; k < sz; k++) mem.delete((int'(addr) & -sz) + k);
                start_cycle();
            end
        end
    end
endmodule

/* tb.sv */
`timescale 1ns/10ps
module tb;
    import sfpw_pkg::*;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
    logic clk = 0, rst = 1, cv = 0, dv = 0, io1;
    sfpw_cmd_t cmd = CMD_WRAP;
    logic [23:0] ca = 24'h0;
    logic [7:0] cw = 8'h0, wd = 8'h0;
    logic [8:0] cl = 9'h0;
    logic cmd_ready_out, wdata_ready_out, done_out, error_out, cs_n, sclk;
    logic [3:0] io, io_oe;
    int failures = 0, n_compared = 0, seed = 32'ha10c, i, j;
    logic [7:0] exp_mem [int];
    logic [7:0] dq [$];
    always #50 clk = ~clk;
    sfpw_host dut (.core_clk_in(clk), .rst_in(rst), .cmd_valid_in(cv), .cmd_in(cmd),
        .cmd_addr_in(ca), .cmd_wrap_in(cw), .cmd_len_in(cl), .wdata_valid_in(dv),
        .wdata_in(wd), .flash_io1_in(io1), .cmd_ready_out(cmd_ready_out),
        .wdata_ready_out(wdata_ready_out), .done_out(done_out), .error_out(error_out),
        .flash_cs_n_out(cs_n), .flash_sclk_out(sclk), .flash_io_out(io),
        .flash_io_oe_out(io_oe));
    sfpw_flash_model mdl (.cs_n_in(cs_n), .sclk_in(sclk), .io_in(io), .io1_out(io1));
    function automatic logic [7:0] rd(int k);
        return mdl.mem.exists(k) ? mdl.mem[k] : 8'hff;
    endfunction
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // called just after an edge; returns just after the done edge
    task automatic run(sfpw_cmd_t c, int a, logic [7:0] w, int n, logic e);
        int t;
        logic seen;
        t = 0;
        seen = 1'b0;
        cmd = c;
        ca = a[23:0];
        cw = w;
        cl = n[8:0];
        cv = 1'b1;
        dv = 1'b1;
        wd = dq.size() ? dq[0] : 8'h00;
        // ready is looked at between edges, never in the edge's own time step
        while (cmd_ready_out !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cv = 1'b0;
        while (!seen && t < 40000) begin
            @(posedge clk);
            #1;
            t++;
            if (wdata_ready_out === 1'b1 && dq.size() > 0) void'(dq.pop_front());
            wd = dq.size() ? dq[0] : 8'h00;
            seen = (done_out === 1'b1);
        end
        dv = 1'b0;
        dq.delete();
        `CHK(seen, 1'b1)
        `CHK(error_out, e)
    endtask
    task automatic cmp_page(int base);
        for (int k = base; k < base + 256; k++) begin
            `CHK(rd(k), (exp_mem.exists(k) ? exp_mem[k] : 8'hff))
        end
    endtask
    task automatic prog(sfpw_cmd_t c, int a, int n);
        for (int k = 0; k < n; k++) begin
            dq.push_back(8'($random(seed)));
            exp_mem[a + k] = dq[k] & (exp_mem.exists(a + k) ? exp_mem[a + k] : 8'hff);
        end
        run(c, a, 8'h00, n, 1'b0);
        cmp_page(a & ~255);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK(mdl.wrap_r, WRAP_DEFAULT)
        for (i = 0; i < 4; i++) begin
            j = $random(seed);
            run(CMD_WRAP, j & 'hffffff, {j[7], i[1:0], 1'b0, j[3:0]}, 1, 1'b0);
            `CHK(mdl.wrap_r, {1'b0, i[1:0], 5'h00})
        end
        run(CMD_WRAP, 0, 8'hff, 1, 1'b0);
        `CHK(mdl.wrap_r, 8'h70)
        prog(CMD_PROG, 'h12f0, 16);
        prog(CMD_PROG, 'h1300, 256);
        prog(CMD_QPROG, 'h1405, 37);
        `CHK(mdl.wrap_r, 8'h70)
        // device withholds the latch: nothing may change
        mdl.wel_block = 1'b1;
        run(CMD_ERASE_64K, 'h1300, 8'h00, 1, 1'b1);
        mdl.wel_block = 1'b0;
        cmp_page('h1300);
        mdl.qe = 1'b0;
        dq.push_back(8'h5a);
        run(CMD_QPROG, 'h1500, 8'h00, 1, 1'b1);
        mdl.qe = 1'b1;
        cmp_page('h1500);
        for (i = 0; i < 3; i++) begin
            j = 4096 << (i == 0 ? 0 : i + 2);
            prog(CMD_PROG, j - 16, 16);
            prog(CMD_PROG, j, 16);
            foreach (exp_mem[k]) if (k < j) exp_mem[k] = 8'hff;
            mdl.busy_ns = 2000 + i * 400000;
            run(sfpw_cmd_t'(CMD_ERASE_4K + i), j / 2 + 'h123, 8'h00, 1, 1'b0);
            cmp_page(j - 256);
            cmp_page(j);
        end
        results();
    end
    initial begin
        #9000000;
        failures++;
        results();
    end
endmodule
